// file: rtl/ulm_top.v
/*
 * Line status and modem status logic for one serial channel: receive
 * FIFO with per-character error bits, overrun detection, modem input
 * mirroring with change latches, loop-back, interrupt status and mask.
 * Assumes the receiver core delivers finished characters on MCLK, and
 * modem pins arrive asynchronously, active low.
 */
// What this block does
// - Framing error reported for top character
// - Parity error reported for top character
// - Overrun set when character arrives while full
// - Overrun character dropped, FIFO contents kept
// - Data ready high while characters held
// - Four change bits set on input change, ring on rise only
// - Reading modem status clears change bits
// - Bit 7 inverted carrier, loop: output two
// - Bit 6 inverted ring, loop: output one
// - Bit 5 inverted DSR, loop: DTR
// - Bit 4 inverted CTS, loop: RTS
// - Bit 3 latches carrier change, interrupts
// - Bit 2 latches ring rise only, interrupts
// - Bits 1, 0 latch DSR, CTS changes
// - Modem interrupt while any change bit set
`default_nettype none
`include "ulm_consts.vh"

module ulm_top #(
  parameter [`ULM_FIFO_AW:0] DEPTH = `ULM_FIFO_DEPTH,
  parameter AW = `ULM_FIFO_AW
) (
  input wire MCLK,
  input wire SRST,
  input wire CE,
  input wire [`ULM_ADDR_W-1:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire RX_VALID,
  input wire [7:0] RX_CHAR,
  input wire RX_PERR,
  input wire RX_FERR,
  input wire CTS_N,
  input wire DSR_N,
  input wire RI_N,
  input wire CD_N,
  output reg DTR_N,
  output reg RTS_N,
  output reg OUT1_N,
  output reg OUT2_N,
  output reg RX_READY,
  output reg MODEM_INT,
  output reg IRQ
);

  // Receive storage
  reg [7:0] data_mem [0:DEPTH-1];
  reg [1:0] err_mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;

  // Software registers
  reg [`ULM_MC_W-1:0] mcr_q;
  reg fifo_en_q;
  reg overrun_q;
  reg [`ULM_IRQ_W-1:0] irq_st_q;
  reg [`ULM_IRQ_W-1:0] irq_mask_q;

  // Decoded accesses
  wire rd_rx;
  wire rd_ls;
  wire rd_ms;
  wire wr_mc;
  wire wr_fc;
  wire wr_ist;
  wire wr_imask;
  wire flush;

  // FIFO control
  wire empty;
  wire full_eff;
  wire pop;
  wire push;
  wire ovr_evt;

  // Modem path, line status and interrupt signals
  wire [3:0] pin_sync;
  wire [3:0] eff_lvl;
  wire [3:0] delta;
  wire [3:0] delta_evt;
  wire loop;
  wire [7:0] line_status;
  wire [7:0] modem_status;
  wire [1:0] top_err;
  wire [`ULM_IRQ_W-1:0] irq_evt;
  wire [`ULM_IRQ_W-1:0] irq_st_d;
  wire [`ULM_IRQ_W-1:0] irq_mask_d;
  wire irq_pend;

  reg [7:0] rdata_d;

  // Order of the modem level group: CTS, DSR, ring, carrier
  localparam IDX_CTS = 0;
  localparam IDX_DSR = 1;
  localparam IDX_RING = 2;
  localparam IDX_CD = 3;

  assign rd_rx = RD & (ADDR == `ULM_OFF_RX_DATA);
  assign rd_ls = RD & (ADDR == `ULM_OFF_LINE_STATUS);
  assign rd_ms = RD & (ADDR == `ULM_OFF_MODEM_STATUS);
  assign wr_mc = WR & (ADDR == `ULM_OFF_MODEM_CONTROL);
  assign wr_fc = WR & (ADDR == `ULM_OFF_FIFO_CONTROL);
  assign wr_ist = WR & (ADDR == `ULM_OFF_IRQ_STATUS);
  assign wr_imask = WR & (ADDR == `ULM_OFF_IRQ_MASK);

  // A mode change also empties the store, so stale depth never leaks
  assign flush = wr_fc &
    (WDATA[`ULM_FC_FLUSH] | (WDATA[`ULM_FC_EN] != fifo_en_q));

  assign loop = mcr_q[`ULM_MC_LOOP];

  // Receive FIFO

  assign empty = (count_q == {(AW+1){1'b0}});

  // Without the FIFO only a single holding register exists
  assign full_eff = fifo_en_q ? (count_q == DEPTH) :
    (count_q != {(AW+1){1'b0}});

  assign pop = rd_rx & ~empty;

  // A pop in the same cycle frees the slot for the new character
  assign ovr_evt = RX_VALID & full_eff & ~pop;
  // A character landing with a flush is lost along with the rest
  assign push = RX_VALID & ~ovr_evt & ~flush;

  always @(posedge MCLK) begin
    if (SRST) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else if (CE) begin
      if (flush) begin
        wr_ptr_q <= {AW{1'b0}};
        rd_ptr_q <= {AW{1'b0}};
        count_q <= {(AW+1){1'b0}};
      end else begin
        if (push) begin
          wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ?
            {AW{1'b0}} : wr_ptr_q + 1'b1;
        end
        if (pop) begin
          rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ?
            {AW{1'b0}} : rd_ptr_q + 1'b1;
        end
        if (push & ~pop) begin
          count_q <= count_q + 1'b1;
        end else if (pop & ~push) begin
          count_q <= count_q - 1'b1;
        end
      end
    end
  end

  // Storage has no reset; empty flag guards every read of it
  always @(posedge MCLK) begin
    if (CE & ~SRST & push) begin
      data_mem[wr_ptr_q] <= RX_CHAR;
      err_mem[wr_ptr_q] <= {RX_FERR, RX_PERR};
    end
  end

  // Error bits follow the character at the top of the store
  assign top_err = empty ? 2'b00 : err_mem[rd_ptr_q];

  // Overrun stays until line status is read; a new one wins the clear
  always @(posedge MCLK) begin
    if (SRST) begin
      overrun_q <= 1'b0;
    end else if (CE) begin
      overrun_q <= (overrun_q & ~rd_ls) | ovr_evt;
    end
  end

  assign line_status = {4'h0,
                        top_err[1],
                        top_err[0],
                        overrun_q,
                        ~empty};

  // Modem control, FIFO control and interrupt mask registers

  always @(posedge MCLK) begin
    if (SRST) begin
      mcr_q <= `ULM_RST_MC;
      fifo_en_q <= 1'b0;
      irq_mask_q <= `ULM_RST_IRQ;
    end else if (CE) begin
      if (wr_mc) begin
        mcr_q <= WDATA[`ULM_MC_W-1:0];
      end
      if (wr_fc) begin
        fifo_en_q <= WDATA[`ULM_FC_EN];
      end
      if (wr_imask) begin
        irq_mask_q <= WDATA[`ULM_IRQ_W-1:0];
      end
    end
  end

  // Modem inputs

  ulm_sync #(
    .W(4)
  ) u_sync (
    .clk(MCLK),
    .srst(SRST),
    .ce(CE),
    .d({CD_N, RI_N, DSR_N, CTS_N}),
    .q(pin_sync)
  );

  // In loop-back the control outputs stand in for the pin levels
  assign eff_lvl = loop ?
    {~mcr_q[`ULM_MC_OUT2], ~mcr_q[`ULM_MC_OUT1],
     ~mcr_q[`ULM_MC_DTR], ~mcr_q[`ULM_MC_RTS]} :
    pin_sync;

  // Deltas see synchronised levels: pulses under one clock may be lost
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_chg
      // Ring only counts its rising pin level
      ulm_chg #(
        .RISE_ONLY((gi == IDX_RING) ? 1 : 0)
      ) u_chg (
        .clk(MCLK),
        .srst(SRST),
        .ce(CE),
        .lvl(eff_lvl[gi]),
        .clr(rd_ms),
        .flag_q(delta[gi]),
        .evt(delta_evt[gi])
      );
    end
  endgenerate

  assign modem_status = {~eff_lvl[IDX_CD],
                         ~eff_lvl[IDX_RING],
                         ~eff_lvl[IDX_DSR],
                         ~eff_lvl[IDX_CTS],
                         delta};

  // Interrupt status: sticky, write one to clear, set wins

  assign irq_evt[`ULM_IRQ_RX] = push;
  assign irq_evt[`ULM_IRQ_LINE] = ovr_evt | (push & (RX_PERR | RX_FERR));
  assign irq_evt[`ULM_IRQ_MODEM] = |delta_evt;

  assign irq_st_d = (irq_st_q & ~({`ULM_IRQ_W{wr_ist}} &
    WDATA[`ULM_IRQ_W-1:0])) | irq_evt;

  // Mask write counts in its own edge, so IRQ never lags a new mask
  assign irq_mask_d = wr_imask ? WDATA[`ULM_IRQ_W-1:0] : irq_mask_q;
  assign irq_pend = |(irq_st_d & irq_mask_d);

  always @(posedge MCLK) begin
    if (SRST) begin
      irq_st_q <= `ULM_RST_IRQ;
    end else if (CE) begin
      irq_st_q <= irq_st_d;
    end
  end

  // Read data mux
  // Unmapped offsets read zero; writes to them are dropped

  always @* begin
    rdata_d = `ULM_RST_BYTE;
    case (ADDR)
      `ULM_OFF_RX_DATA: begin
        rdata_d = empty ? `ULM_RST_BYTE : data_mem[rd_ptr_q];
      end
      `ULM_OFF_MODEM_CONTROL: begin
        rdata_d = {{(8-`ULM_MC_W){1'b0}}, mcr_q};
      end
      `ULM_OFF_FIFO_CONTROL: begin
        rdata_d = {7'h00, fifo_en_q};
      end
      `ULM_OFF_LINE_STATUS: begin
        rdata_d = line_status;
      end
      `ULM_OFF_MODEM_STATUS: begin
        rdata_d = modem_status;
      end
      `ULM_OFF_IRQ_STATUS: begin
        rdata_d = {{(8-`ULM_IRQ_W){1'b0}}, irq_st_q};
      end
      `ULM_OFF_IRQ_MASK: begin
        rdata_d = {{(8-`ULM_IRQ_W){1'b0}}, irq_mask_q};
      end
      default: begin
        rdata_d = `ULM_RST_BYTE;
      end
    endcase
  end

  // Read data holds only for the cycle after the strobe
  always @(posedge MCLK) begin
    if (SRST) begin
      RDATA <= `ULM_RST_BYTE;
    end else if (CE) begin
      RDATA <= RD ? rdata_d : `ULM_RST_BYTE;
    end
  end

  // Registered outputs

  always @(posedge MCLK) begin
    if (SRST) begin
      DTR_N <= 1'b1;
      RTS_N <= 1'b1;
      OUT1_N <= 1'b1;
      OUT2_N <= 1'b1;
      RX_READY <= 1'b0;
      MODEM_INT <= 1'b0;
      IRQ <= 1'b0;
    end else if (CE) begin
      // Loop-back keeps the real pins idle
      DTR_N <= loop | ~mcr_q[`ULM_MC_DTR];
      RTS_N <= loop | ~mcr_q[`ULM_MC_RTS];
      OUT1_N <= loop | ~mcr_q[`ULM_MC_OUT1];
      OUT2_N <= loop | ~mcr_q[`ULM_MC_OUT2];
      RX_READY <= ~empty;
      MODEM_INT <= |delta;
      // Level follows next status and mask, so clears act at once
      IRQ <= irq_pend;
    end
  end

endmodule // ulm_top
`default_nettype wire

// file: rtl/ulm_consts.vh
/*
 * Register offsets, field positions, reset values and sizes for the
 * line and modem status block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ULM_CONSTS_VH
`define ULM_CONSTS_VH

// Register offsets (4-bit word address)
`define ULM_ADDR_W 4
`define ULM_OFF_RX_DATA 4'h0
`define ULM_OFF_MODEM_CONTROL 4'h1
`define ULM_OFF_FIFO_CONTROL 4'h2
`define ULM_OFF_LINE_STATUS 4'h5
`define ULM_OFF_MODEM_STATUS 4'h6
`define ULM_OFF_IRQ_STATUS 4'h8
`define ULM_OFF_IRQ_MASK 4'h9

// line_status fields
`define ULM_LS_DR 0
`define ULM_LS_OE 1
`define ULM_LS_PE 2
`define ULM_LS_FE 3

// modem_control fields
`define ULM_MC_DTR 0
`define ULM_MC_RTS 1
`define ULM_MC_OUT1 2
`define ULM_MC_OUT2 3
`define ULM_MC_LOOP 4
`define ULM_MC_W 5

// fifo_control fields
`define ULM_FC_EN 0
`define ULM_FC_FLUSH 1

// Interrupt status / mask fields
`define ULM_IRQ_RX 0
`define ULM_IRQ_LINE 1
`define ULM_IRQ_MODEM 2
`define ULM_IRQ_W 3

// Reset values
`define ULM_RST_BYTE 8'h00
`define ULM_RST_MC 5'h00
`define ULM_RST_IRQ 3'h0
`define ULM_RST_PIN 1'b1

// Receive FIFO size
`define ULM_FIFO_DEPTH 32
`define ULM_FIFO_AW 5

`endif

// file: rtl/ulm_sync.v
/*
 * Two-flop synchroniser for a group of asynchronous pin levels.
 * Assumes the pins are active low and idle high.
 */
`default_nettype none
`include "ulm_consts.vh"

module ulm_sync #(
  parameter W = 4
) (
  input wire clk,
  input wire srst,
  input wire ce,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_q;

  always @(posedge clk) begin
    if (srst) begin
      meta_q <= {W{`ULM_RST_PIN}};
      q <= {W{`ULM_RST_PIN}};
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // ulm_sync
`default_nettype wire

// file: rtl/ulm_chg.v
/*
 * Sticky change indicator for one modem control level.
 * Assumes a synchronised level and a one-cycle clear pulse.
 */
`default_nettype none
`include "ulm_consts.vh"

module ulm_chg #(
  parameter RISE_ONLY = 0
) (
  input wire clk,
  input wire srst,
  input wire ce,
  input wire lvl,
  input wire clr,
  output reg flag_q,
  output wire evt
);

  reg prev_q;

  // Ring only reports the low-to-high transition
  assign evt = (RISE_ONLY != 0) ? (lvl & ~prev_q) : (lvl ^ prev_q);

  always @(posedge clk) begin
    if (srst) begin
      prev_q <= `ULM_RST_PIN;
      flag_q <= 1'b0;
    end else if (ce) begin
      prev_q <= lvl;
      // Set wins over a simultaneous read clear
      flag_q <= (flag_q & ~clr) | evt;
    end
  end

endmodule // ulm_chg
`default_nettype wire

// file: verif/ulm_chk.sv
/* Port assertions for the status block.
   Assumes a bind to ulm_top, one clock MCLK. */
`default_nettype none
module ulm_chk (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic RX_VALID,
  input wire logic CTS_N,
  input wire logic DSR_N,
  input wire logic RI_N,
  input wire logic CD_N,
  input wire logic DTR_N,
  input wire logic RX_READY,
  input wire logic MODEM_INT
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mc_q;
  wire logic [3:0] pins = {CD_N, RI_N, DSR_N, CTS_N};
  wire logic mc_wr = CE && WR && ADDR == 4'h1;
  // Shadow of modem_control: loop-back is not visible at the pins
  always @(posedge MCLK)
    if (SRST) mc_q <= 8'h00;
    else if (mc_wr) mc_q <= WDATA;
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (SRST);
  a_reset_values: assert property (disable iff (1'b0)
    SRST |=> RDATA == 8'h00 && !MODEM_INT && !RX_READY && DTR_N)
    else $error("reset values");
  a_ready_sets: assert property (
    CE && RX_VALID && !RD && !WR ##1 CE && !RD && !WR |=> RX_READY)
    else $error("ready late");
  a_ready_clears: assert property (
    $fell(RX_READY) && !$past(SRST) |-> $past(RD, 2) || $past(WR, 2))
    else $error("ready dropped");
  a_status_ready: assert property (
    CE && RD && ADDR == 4'h5 && RX_READY && !$past(RD) && !$past(WR)
    |=> RDATA[0]) else $error("data ready bit");
  a_int_sets: assert property (
    $changed(pins) && !$fell(RI_N) && !DTR_N |-> ##4 MODEM_INT)
    else $error("modem int late");
  a_int_clears: assert property (
    $fell(MODEM_INT) && !$past(SRST) |-> $past(RD, 2)
    && $past(ADDR, 2) == 4'h6) else $error("modem int dropped");
  a_pin_levels: assert property (
    ($stable(pins) && !mc_wr)[*4] ##1 CE && RD && ADDR == 4'h6
    && !mc_q[4] |=> RDATA[7:4] == ~$past(pins, 3)) else $error("levels");
  a_loop_levels: assert property (
    (!mc_wr)[*4] ##1 CE && RD && ADDR == 4'h6 && mc_q[4]
    |=> RDATA[7:4] == {mc_q[3:2], mc_q[0], mc_q[1]})
    else $error("loop levels");
endmodule // ulm_chk
bind ulm_top ulm_chk chk_i (.*);
`default_nettype wire

// file: verif/ulm_modem.sv
/* Modem peer: drives the four active-low control pins.
   Assumes the bench requests levels; pins idle high. */
`default_nettype none
module ulm_modem (
  input wire logic clk,
  input wire logic [3:0] want,
  input wire logic slow,
  output logic [3:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] hold_q = 4'hf;
  initial pins = 4'hf;
  // A slow peer lags one more cycle
  always @(posedge clk) begin
    hold_q <= want;
    pins <= slow ? hold_q : want;
  end
endmodule // ulm_modem
`default_nettype wire

// file: verif/uart_line_modem_status_tb_top.sv
/* Self-checking bench for ulm_top with a modem peer.
   Assumes design, peer and checker are compiled first. */
`default_nettype none
module uart_line_modem_status_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, srst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
  logic slow = 1'b0, rx_valid = 1'b0, rx_perr = 1'b0, rx_ferr = 1'b0;
  logic [3:0] addr = 4'h0, want = 4'hf, pins;
  logic [7:0] wdata = 8'h00, rx_char = 8'h00, rdata;
  logic dtr_n, rts_n, out1_n, out2_n, rx_ready, modem_int, irq;
  int err_count = 0, check_count = 0, cyc = 0;
  logic [9:0] q[$];
  always #25 mclk = ~mclk;
  ulm_modem peer (.clk(mclk), .want(want), .slow(slow), .pins(pins));
  ulm_top dut (.MCLK(mclk), .SRST(srst), .CE(ce), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RX_VALID(rx_valid),
    .RX_CHAR(rx_char), .RX_PERR(rx_perr), .RX_FERR(rx_ferr),
    .CTS_N(pins[0]), .DSR_N(pins[1]), .RI_N(pins[2]), .CD_N(pins[3]),
    .DTR_N(dtr_n), .RTS_N(rts_n), .OUT1_N(out1_n), .OUT2_N(out2_n),
    .RX_READY(rx_ready), .MODEM_INT(modem_int), .IRQ(irq));
  task automatic give_verdict();
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp,
    input logic [7:0] m = 8'hff);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata & m, exp);
  endtask
  function automatic logic [7:0] ls(input logic [9:0] e);
    return {4'h0, e[9:8], 2'b01};
  endfunction
  // One character more than fits, so the last one overruns
  task automatic run_rx(input int depth);
    logic [9:0] e;
    repeat (depth + 1) begin
      e = 10'($urandom);
      @(posedge mclk);
      rx_valid <= 1'b1;
      {rx_ferr, rx_perr, rx_char} <= e;
      if (q.size() < depth)
        q.push_back(e);
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    rd_reg(4'h5, ls(q[0]) | 8'h02);
    while (q.size() > 0) begin
      e = q.pop_front();
      rd_reg(4'h0, e[7:0]);
      rd_reg(4'h5, q.size() > 0 ? ls(q[0]) : 8'h00);
    end
  endtask
  // Far above the run's real length
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    logic [3:0] d, v;
    int i;
    i = $urandom(32'h4630);
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    rd_reg(4'h5, 8'h00);
    rd_reg(4'h6, 8'h00);
    run_rx(1);
    wr_reg(4'h2, 8'h01);
    rd_reg(4'h2, 8'h01);
    run_rx(32);
    wr_reg(4'h1, 8'h01);
    repeat (12) begin
      i = $urandom % 4;
      d = (i != 2 || !want[i]) ? 4'(1 << i) : 4'h0;
      @(posedge mclk);
      want <= want ^ 4'(1 << i);
      slow <= 1'($urandom);
      repeat (8) @(posedge mclk);
      #1 chk({7'h0, modem_int}, {7'h0, |d});
      rd_reg(4'h6, {~want, d});
      rd_reg(4'h6, {~want, 4'h0});
    end
    repeat (4) begin
      v = 4'($urandom);
      wr_reg(4'h1, {4'h1, v});
      repeat (5) @(posedge mclk);
      d = {v[3:2], v[0], v[1]};
      rd_reg(4'h6, {d, 4'h0}, 8'hf0);
      chk({out2_n, out1_n, rts_n, dtr_n, 4'h0}, 8'hf0);
    end
    // Leaving loop-back, the last pattern must reach the real pins
    wr_reg(4'h1, {4'h0, v});
    repeat (5) @(posedge mclk);
    rd_reg(4'h6, {~want, 4'h0}, 8'hf0);
    chk({out2_n, out1_n, rts_n, dtr_n, 4'h0}, {~v, 4'h0});
    rd_reg(4'hf, 8'h00);
    @(posedge mclk);
    ce <= 1'b0;
    rx_valid <= 1'b1;
    @(posedge mclk);
    ce <= 1'b1;
    rx_valid <= 1'b0;
    rd_reg(4'h5, 8'h00);
    chk({7'h0, irq}, 8'h00);
    rd_reg(4'h8, 8'h07);
    wr_reg(4'h9, 8'h04);
    rd_reg(4'h9, 8'h04);
    repeat (2) @(posedge mclk);
    #1 chk({7'h0, irq}, 8'h01);
    wr_reg(4'h8, 8'h04);
    repeat (2) @(posedge mclk);
    #1 chk({7'h0, irq}, 8'h00);
    rd_reg(4'h8, 8'h03);
    // Flush empties the store while FIFO mode stays on
    @(posedge mclk);
    rx_valid <= 1'b1;
    @(posedge mclk);
    rx_valid <= 1'b0;
    wr_reg(4'h2, 8'h03);
    rd_reg(4'h5, 8'h00);
    // Mid-run reset with a character held and pins as they stand
    @(posedge mclk);
    rx_valid <= 1'b1;
    @(posedge mclk);
    rx_valid <= 1'b0;
    srst <= 1'b1;
    @(posedge mclk);
    srst <= 1'b0;
    rd_reg(4'h5, 8'h00);
    rd_reg(4'h8, 8'h00, 8'h03);
    rd_reg(4'h2, 8'h00);
    chk({out2_n, out1_n, rts_n, dtr_n, 4'h0}, 8'hf0);
    give_verdict();
  end
endmodule // uart_line_modem_status_tb_top
`default_nettype wire
